// ===== lsp_regs.vh
// register map, field positions, reset values and array shapes of the port
// assumes byte addressing on a 32-bit classic wishbone slave
`ifndef LSP_REGS_VH
`define LSP_REGS_VH

// ======================================================================
// array organisation
`define LSP_WIDE_ADDR_W    18
`define LSP_NARROW_ADDR_W  19
`define LSP_WIDE_LANES     4
`define LSP_NARROW_LANES   2
`define LSP_LANE_W         9

// ======================================================================
// register offsets (byte addresses)
`define LSP_CTRL_OFS       8'h00
`define LSP_STAT_OFS       8'h04
`define LSP_CNT_OFS        8'h08
`define LSP_BUFA_OFS       8'h0C

// ======================================================================
// control fields
`define LSP_CTRL_EN_BIT    0
`define LSP_CTRL_RST       1'h1

// ======================================================================
// status fields
`define LSP_STAT_SLEEP_BIT 0
`define LSP_STAT_BUFV_BIT  1
`define LSP_STAT_STRAP_BIT 2
`define LSP_STAT_DRV_BIT   3
`define LSP_STAT_PEND_BIT  4

// ======================================================================
// counter fields
`define LSP_CNT_WR_LSB     0
`define LSP_CNT_RD_LSB     16
`define LSP_CNT_W          16

`endif

// ===== lsp_sync3.v
// three-stage synchroniser for pins from outside the clock domain
// assumes one clock; a change is taken once stages two and three agree
module lsp_sync3 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] level_o
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] out_q;
  integer     i;

  // ======================================================================
  // stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      out_q <= {W{1'b0}};
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level_o = out_q;

endmodule

// ===== lsp_late_buf.v
// one-entry late write buffer with per-lane read bypass
// assumes loads come from the port's own clocked logic
module lsp_late_buf #(
  parameter ADDR_W = 18,
  parameter LANES  = 4,
  parameter LANE_W = 9,
  parameter DATA_W = LANES * LANE_W
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              load_i,
  input  wire [ADDR_W-1:0] addr_i,
  input  wire [DATA_W-1:0] data_i,
  input  wire [LANES-1:0]  lane_write_n_i,
  input  wire [ADDR_W-1:0] look_addr_i,
  input  wire [DATA_W-1:0] array_word_i,
  output wire [DATA_W-1:0] merged_o,
  output wire              valid_o,
  output wire [ADDR_W-1:0] addr_o,
  output wire [DATA_W-1:0] data_o,
  output wire [LANES-1:0]  lane_write_n_o
);

  reg              valid_q;
  reg [ADDR_W-1:0] addr_q;
  reg [DATA_W-1:0] data_q;
  reg [LANES-1:0]  bw_n_q;
  wire             hit;

  // ======================================================================
  // buffer entry
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      addr_q  <= {ADDR_W{1'b0}};
      data_q  <= {DATA_W{1'b0}};
      bw_n_q  <= {LANES{1'b1}};
    end else if (load_i) begin
      valid_q <= 1'b1;
      addr_q  <= addr_i;
      data_q  <= data_i;
      bw_n_q  <= lane_write_n_i;
    end
  end

  // ======================================================================
  // bypass: pending bytes win over stale array bytes
  assign hit = valid_q && (addr_q == look_addr_i);

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      assign merged_o[l*LANE_W +: LANE_W] = (hit && !bw_n_q[l]) ?
        data_q[l*LANE_W +: LANE_W] :
        array_word_i[l*LANE_W +: LANE_W];
    end
  endgenerate

  assign valid_o        = valid_q;
  assign addr_o         = addr_q;
  assign data_o         = data_q;
  assign lane_write_n_o = bw_n_q;

endmodule

// ===== lsp_port.v
// late write synchronous sram port: input registers, array, one-deep
// write buffer, output latch and a small wishbone status block
// assumes the controller runs on clk_i and the array clock is clk_i

`include "lsp_regs.vh"

module lsp_port #(
  parameter WIDE   = 1,
  parameter LANE_W = `LSP_LANE_W,
  parameter ADDR_W = WIDE ? `LSP_WIDE_ADDR_W : `LSP_NARROW_ADDR_W,
  parameter LANES  = WIDE ? `LSP_WIDE_LANES : `LSP_NARROW_LANES,
  parameter DATA_W = LANES * LANE_W
) (
  input  wire              clk_i,
  input  wire              rst_i,
  // memory pins
  input  wire [ADDR_W-1:0] word_address_in_i,
  input  wire              select_n_i,
  input  wire              global_write_n_i,
  input  wire [LANES-1:0]  lane_write_n_i,
  input  wire              out_enable_n_i,
  input  wire              sleep_request_i,
  input  wire              protocol_strap_hi_i,
  input  wire              protocol_strap_lo_i,
  input  wire [DATA_W-1:0] data_lanes_i,
  output wire [DATA_W-1:0] data_lanes_o,
  output wire              data_lanes_oe_o,
  output wire              low_power_o,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output wire [31:0]       wb_dat_o,
  output wire              wb_ack_o
);

  // ======================================================================
  // organisation: the narrow part trades two lanes for one address bit
  localparam WIDE_WORDS   = 1 << `LSP_WIDE_ADDR_W;
  localparam NARROW_WORDS = 1 << `LSP_NARROW_ADDR_W;
  localparam DEPTH        = WIDE ? WIDE_WORDS : NARROW_WORDS;

  // ======================================================================
  // declarations
  reg  [DATA_W-1:0]     mem [0:DEPTH-1];

  reg  [ADDR_W-1:0]     addr_q;
  reg                   rd_q;
  reg                   wr_q;
  reg  [LANES-1:0]      bw_n_q;
  reg  [DATA_W-1:0]     out_q;
  reg                   drive_q;

  reg                   en_q;
  reg                   strap_ok_q;
  reg  [`LSP_CNT_W-1:0] wr_cnt_q;
  reg  [`LSP_CNT_W-1:0] rd_cnt_q;
  reg                   ack_q;
  reg  [31:0]           rdat_q;
  reg  [31:0]           rdat_d;

  wire                  accept;
  wire                  take_rd;
  wire                  take_wr;
  wire [DATA_W-1:0]     merged;
  wire                  buf_valid;
  wire [ADDR_W-1:0]     buf_addr;
  wire [DATA_W-1:0]     buf_data;
  wire [LANES-1:0]      buf_bw_n;
  wire [2:0]            pin_sync;
  wire                  sleep_s;
  wire                  strap_hi_s;
  wire                  strap_lo_s;
  wire                  wb_req;
  wire                  wb_wr;
  wire                  cnt_clr;
  wire [`LSP_CNT_W-1:0] wr_inc;
  wire [`LSP_CNT_W-1:0] rd_inc;
  wire                  bus_gate;
  wire                  commit_now;
  integer               i;

  // ======================================================================
  // cycle decode
  // sleep gates the decode directly, so no edge is needed to enter it
  assign low_power_o = sleep_request_i;
  assign accept  = !select_n_i && !sleep_request_i && en_q;
  assign take_rd = accept && global_write_n_i;
  assign take_wr = accept && !global_write_n_i;

  // ======================================================================
  // input registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= {ADDR_W{1'b0}};
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      bw_n_q <= {LANES{1'b1}};
    end else begin
      addr_q <= word_address_in_i;
      rd_q   <= take_rd;
      wr_q   <= take_wr;
      bw_n_q <= lane_write_n_i;
    end
  end

  // ======================================================================
  // late write buffer
  // data of the write addressed last cycle is captured now and parked;
  // the entry it replaces is committed in the same edge
  lsp_late_buf #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W),
    .DATA_W (DATA_W)
  ) u_buf (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .load_i         (wr_q),
    .addr_i         (addr_q),
    .data_i         (data_lanes_i),
    .lane_write_n_i (bw_n_q),
    .look_addr_i    (addr_q),
    .array_word_i   (mem[addr_q]),
    .merged_o       (merged),
    .valid_o        (buf_valid),
    .addr_o         (buf_addr),
    .data_o         (buf_data),
    .lane_write_n_o (buf_bw_n)
  );

  // ======================================================================
  // array commit
  // no reset on the array: contents are undefined until written
  // the old entry leaves only when a new one arrives, so no write is lost
  assign commit_now = wr_q && buf_valid;

  always @(posedge clk_i) begin
    if (commit_now) begin
      for (i = 0; i < LANES; i = i + 1) begin
        if (!buf_bw_n[i]) begin
          mem[buf_addr][i*LANE_W +: LANE_W] <=
            buf_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ======================================================================
  // output latch on the falling edge
  // merged data includes a write parked in this very rising edge
  always @(negedge clk_i) begin
    if (rst_i) begin
      out_q   <= {DATA_W{1'b0}};
      drive_q <= 1'b0;
    end else begin
      drive_q <= rd_q;
      if (rd_q) begin
        out_q <= merged;
      end
    end
  end

  assign data_lanes_o    = out_q;
  // enable and sleep act combinationally on the drivers
  assign bus_gate        = !out_enable_n_i && !sleep_request_i;
  assign data_lanes_oe_o = drive_q && bus_gate;

  // ======================================================================
  // status pins, synchronised for software only
  lsp_sync3 #(
    .W (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({sleep_request_i, protocol_strap_hi_i, protocol_strap_lo_i}),
    .level_o (pin_sync)
  );

  assign sleep_s    = pin_sync[2];
  assign strap_hi_s = pin_sync[1];
  assign strap_lo_s = pin_sync[0];

  // straps are sampled after reset release, never under reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_ok_q <= 1'b0;
    end else begin
      strap_ok_q <= strap_hi_s && !strap_lo_s;
    end
  end

  // ======================================================================
  // wishbone slave
  assign wb_req  = wb_cyc_i && wb_stb_i;
  assign wb_wr   = wb_req && wb_we_i && ack_q;
  assign cnt_clr = wb_wr && (wb_adr_i == `LSP_CNT_OFS) && (|wb_sel_i);

  always @* begin
    rdat_d = 32'h0000_0000;
    case (wb_adr_i)
      `LSP_CTRL_OFS: begin
        rdat_d[`LSP_CTRL_EN_BIT] = en_q;
      end
      `LSP_STAT_OFS: begin
        rdat_d[`LSP_STAT_SLEEP_BIT] = sleep_s;
        rdat_d[`LSP_STAT_BUFV_BIT]  = buf_valid;
        rdat_d[`LSP_STAT_STRAP_BIT] = strap_ok_q;
        rdat_d[`LSP_STAT_DRV_BIT]   = drive_q;
        rdat_d[`LSP_STAT_PEND_BIT]  = wr_q;
      end
      `LSP_CNT_OFS: begin
        rdat_d[`LSP_CNT_WR_LSB +: `LSP_CNT_W] = wr_cnt_q;
        rdat_d[`LSP_CNT_RD_LSB +: `LSP_CNT_W] = rd_cnt_q;
      end
      `LSP_BUFA_OFS: begin
        rdat_d[ADDR_W-1:0] = buf_addr;
      end
      default: begin
        rdat_d = 32'h0000_0000;
      end
    endcase
  end

  // one wait state: ack in the cycle after the request, for one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      en_q   <= `LSP_CTRL_RST;
    end else begin
      ack_q <= wb_req && !ack_q;
      if (wb_req && !ack_q) begin
        rdat_q <= rdat_d;
      end
      if (wb_wr && (wb_adr_i == `LSP_CTRL_OFS) && wb_sel_i[0]) begin
        en_q <= wb_dat_i[`LSP_CTRL_EN_BIT];
      end
    end
  end

  // ======================================================================
  // activity counters: a count in the clearing cycle is kept
  // counters wrap silently; software reads them often enough to notice
  assign wr_inc = {{(`LSP_CNT_W-1){1'b0}}, take_wr};
  assign rd_inc = {{(`LSP_CNT_W-1){1'b0}}, take_rd};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_q <= {`LSP_CNT_W{1'b0}};
      rd_cnt_q <= {`LSP_CNT_W{1'b0}};
    end else if (cnt_clr) begin
      wr_cnt_q <= wr_inc;
      rd_cnt_q <= rd_inc;
    end else begin
      wr_cnt_q <= wr_cnt_q + wr_inc;
      rd_cnt_q <= rd_cnt_q + rd_inc;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule

// ===== lsp_port_sva.sv
// checker for the sram pins and the wishbone handshake of lsp_port
// assumes it is bound into lsp_port and sees only its ports
module lsp_port_chk #(
  parameter DATA_W = 36
) (
  input wire              clk_i,
  input wire              rst_i,
  input wire              select_n_i,
  input wire              global_write_n_i,
  input wire              out_enable_n_i,
  input wire              sleep_request_i,
  input wire [DATA_W-1:0] data_lanes_o,
  input wire              data_lanes_oe_o,
  input wire              low_power_o,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_ack_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==================================================================
  // cycle decode
  sequence s_rd;
    !select_n_i && global_write_n_i && !sleep_request_i;
  endsequence
  sequence s_shown;
    !out_enable_n_i && !sleep_request_i;
  endsequence
  property p_rd_drive;
    s_rd ##1 s_shown |-> data_lanes_oe_o;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");
  // sleep counts as a non-read cycle, so it also ends a drive stretch
  property p_desel;
    select_n_i || !global_write_n_i || sleep_request_i |=> !data_lanes_oe_o;
  endproperty
  a_desel: assert property (p_desel)
    else $error("bus driven after non-read");
  property p_hold;
    select_n_i || !global_write_n_i || sleep_request_i
      |=> $stable(data_lanes_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read latch changed without read");
  property p_oe_off;
    out_enable_n_i |-> !data_lanes_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("driving with enable high");
  property p_sleep_drv;
    sleep_request_i |-> !data_lanes_oe_o;
  endproperty
  a_sleep_drv: assert property (p_sleep_drv)
    else $error("driving in sleep");
  property p_lp;
    low_power_o == sleep_request_i;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low power not following sleep");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single pulse after one wait");
  property p_ack_req;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
endmodule

// ===== lsp_ctl_model.sv
// memory controller model: one cycle on the pins per call of op
// assumes the bench resolves the shared data wire from both enables
module lsp_ctl_model (
  input  wire         clk_i,
  input  wire  [35:0] bus_i,
  output logic [17:0] addr_o,
  output logic        sel_n_o,
  output logic        we_n_o,
  output logic [3:0]  lanes_o,
  output logic [35:0] dat_o,
  output logic        dat_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {addr_o, lanes_o, dat_o, dat_oe_o} = '0;
    {sel_n_o, we_n_o} = 2'b11;
  end
  // ==================================================================
  // k: 0 idle, 1 read, 2 write; q is the wire seen at this op's edge
  task automatic op(input int k, input logic [17:0] a,
                    input logic [35:0] d, input logic [3:0] l,
                    output logic [35:0] q);
    sel_n_o <= (k == 0);
    we_n_o <= (k != 2);
    addr_o <= a;
    lanes_o <= l;
    @(posedge clk_i);
    q = bus_i;
    // no write pulse: only the clocked strobes above
    dat_oe_o <= (k == 2);
    dat_o <= d;
  endtask
endmodule

// ===== tb.sv
// bench for lsp_port, wide variant, controller model on the pins
// assumes the checker and the controller model are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, oe_n = 0, zz = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = '0;
  logic [31:0] wdat = '0, r;
  logic [35:0] last = '0, q, e;
  logic [35:0] mem [int];
  wire  [31:0] rdat;
  wire  [17:0] ma;
  wire  [35:0] cd, dq, bus;
  wire  [3:0]  ln;
  wire         ack, sn, wn, coe, doe, lp;
  int          n_mismatch = 0, n_compared = 0, prv = 0, nw = 0, nr = 0;
  always #10 clk = ~clk;
  // undriven wire flips every cycle so stale data cannot pass
  assign bus = doe ? dq : (coe ? cd : ~last);
  always @(posedge clk) last <= bus;
  lsp_ctl_model lsp_ctl_model_i (.clk_i(clk), .bus_i(bus), .addr_o(ma),
    .sel_n_o(sn), .we_n_o(wn), .lanes_o(ln), .dat_o(cd), .dat_oe_o(coe));
  lsp_port lsp_port_i (.clk_i(clk), .rst_i(rst), .word_address_in_i(ma),
    .select_n_i(sn), .global_write_n_i(wn), .lane_write_n_i(ln),
    .out_enable_n_i(oe_n), .sleep_request_i(zz),
    .protocol_strap_hi_i(1'b1), .protocol_strap_lo_i(1'b0),
    .data_lanes_i(bus), .data_lanes_o(dq), .data_lanes_oe_o(doe),
    .low_power_o(lp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  // ==================================================================
  // helpers
  function automatic logic [35:0] rnd();
    return 36'({$urandom, $urandom});
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one memory cycle; the model applies writes at once, which is what a
  // coherent buffer must show to any later read
  task automatic go(input int k, input int a, input logic [35:0] d,
                    input int l);
    if (prv == 1 && k == 2) go(0, 0, 0, 0);
    lsp_ctl_model_i.op(k, 18'(a), d, 4'(l), q);
    if (prv == 1) chk(q, e);
    prv = (zz || oe_n) ? 0 : k;
    if (!zz && k == 2) begin
      for (int i = 0; i < 4; i++)
        if (!l[i]) mem[a][9*i +: 9] = d[9*i +: 9];
      nw++;
    end
    if (!zz && k == 1) begin
      e = mem[a];
      nr++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] g);
    int n;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    g = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  // ==================================================================
  // tests; the narrow variant is left to a second build
  initial begin
    void'($urandom(32'h8676));
    repeat (3) @(posedge clk);
    chk(36'({doe, ack}), 36'h0);
    rst <= 0;
    for (int i = 0; i < 9; i++) go(2, i == 8 ? 18'h3FFFF : i, rnd(), 0);
    for (int i = 0; i < 9; i++) go(1, i == 8 ? 18'h3FFFF : i, 0, 0);
    $display("test fill done");
    for (int s = 0; s < 16; s++) begin
      go(2, 3, rnd(), s);
      go(1, 3, 0, 0);
    end
    $display("test lanes done");
    for (int i = 0; i < 300; i++)
      go($urandom_range(2, 0), $urandom_range(7, 0), rnd(),
         $urandom_range(15, 0));
    $display("test random done");
    go(0, 0, 0, 0);
    zz <= 1;
    go(1, 2, 0, 0);
    go(2, 2, rnd(), 0);
    chk(36'({lp, doe}), 36'h2);
    zz <= 0;
    go(1, 2, 0, 0);
    go(1, 4, 0, 0);
    oe_n <= 1;
    #1 chk(36'(doe), 36'h0);
    prv = 0;
    go(1, 4, 0, 0);
    oe_n <= 0;
    go(0, 0, 0, 0);
    $display("test sleep and enable done");
    wb(1, 8'h08, 32'h0, r);
    {nw, nr} = '0;
    for (int i = 0; i < 3; i++) go(2, 5 + i, rnd(), 0);
    for (int i = 0; i < 2; i++) go(1, 5 + i, 0, 0);
    go(0, 0, 0, 0);
    wb(0, 8'h08, 32'h0, r);
    chk(36'(r), 36'({16'(nr), 16'(nw)}));
    wb(0, 8'h04, 32'h0, r);
    chk(36'(r), 36'h6);
    wb(0, 8'h0C, 32'h0, r);
    chk(36'(r), 36'h7);
    wb(0, 8'h00, 32'h0, r);
    chk(36'(r), 36'h1);
    wb(1, 8'h10, 32'hFFFFFFFF, r);
    wb(0, 8'h10, 32'h0, r);
    chk(36'(r), 36'h0);
    $display("test registers done");
    print_verdict();
  end
  // tests need about 500 cycles; twenty times that means a hang
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
bind lsp_port lsp_port_chk #(.DATA_W(DATA_W)) lsp_port_chk_i (.clk_i,
  .rst_i, .select_n_i, .global_write_n_i, .out_enable_n_i,
  .sleep_request_i, .data_lanes_o, .data_lanes_oe_o, .low_power_o,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o);
